// file: phys_filter_defs.vh
// Purpose: Shared constants of the physical request node filter
// Assumes: Included by bare name from every design file
// Notes: Offsets are byte addresses of 32-bit words
`ifndef PHYS_FILTER_DEFS_VH
`define PHYS_FILTER_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_HIGH_SET 12'h110
`define OFF_HIGH_CLR 12'h114
`define OFF_LOW_SET 12'h118
`define OFF_LOW_CLR 12'h11C
`define OFF_UPPER_BOUND 12'h120
`define OFF_STATUS 12'h124
`define OFF_CNT_ROUTE 12'h128
`define OFF_CNT_REJECT 12'h12C

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define MASK_LOW_RST 32'h0000_0000
`define MASK_HIGH_RST 32'h0000_0000
`define UPPER_BOUND_VAL 32'h0000_0000
`define ALL_BUS_BIT 63
`define NODE_NUM_W 6
`define MASK_W 64

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Route codes, as shown in the status word
// ----------------------------------------------------------------
`define ROUTE_NONE 2'h0
`define ROUTE_PHYS 2'h1
`define ROUTE_ASYNC 2'h2
`define ROUTE_REJECT 2'h3

`endif

// file: phys_route_decide.v
// Purpose: Registered routing decision for one received request
// Assumes: Packet inputs come from link logic on the same clock
// Notes: One packet per cycle at most; result one cycle later
`timescale 1ns/1ps
`include "phys_filter_defs.vh"

module phys_route_decide #(
  parameter NODE_W = 6,
  parameter MASK_W = 64
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // Node mask
  input wire [MASK_W-1:0] node_mask_in,
  // Received packet
  input wire pkt_valid_in,
  input wire [NODE_W-1:0] pkt_src_node_in,
  input wire pkt_src_local_in,
  input wire pkt_phys_in,
  input wire async_filter_pass_in,
  // Decision
  output reg route_valid_out,
  output reg route_phys_out,
  output reg route_async_out,
  output reg route_reject_out,
  output reg [NODE_W-1:0] route_node_out
);

  // ----------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------
  reg [1:0] route_nxt;
  wire node_bit;

  // Top bit is the remote-bus accept, never a node, so node 63 misses
  assign node_bit = (pkt_src_node_in == {NODE_W{1'b1}}) ? 1'b0 : node_mask_in[pkt_src_node_in];

  always @*
  begin
    route_nxt = `ROUTE_NONE;
    if (pkt_valid_in)
    begin
      if (!pkt_phys_in)
        route_nxt = async_filter_pass_in ? `ROUTE_ASYNC : `ROUTE_REJECT;
      else if (!pkt_src_local_in)
        route_nxt = node_mask_in[`ALL_BUS_BIT] ? `ROUTE_PHYS : `ROUTE_REJECT;
      else if (!async_filter_pass_in)
        route_nxt = `ROUTE_REJECT;
      else if (node_bit)
        route_nxt = `ROUTE_PHYS;
      else
        route_nxt = `ROUTE_ASYNC;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      route_valid_out <= 1'b0;
      route_phys_out <= 1'b0;
      route_async_out <= 1'b0;
      route_reject_out <= 1'b0;
      route_node_out <= {NODE_W{1'b0}};
    end
    else
    begin
      route_valid_out <= pkt_valid_in;
      route_phys_out <= (route_nxt == `ROUTE_PHYS);
      route_async_out <= (route_nxt == `ROUTE_ASYNC);
      route_reject_out <= (route_nxt == `ROUTE_REJECT);
      if (pkt_valid_in)
        route_node_out <= pkt_src_node_in;
    end
  end

endmodule

// file: physical_request_node_filter.v
// Purpose: Per-node physical request filter with AXI4-Lite registers
// Assumes: Link packet inputs and bus reset are on mclk_in
// Notes: One write and one read in flight; unmapped words answer SLVERR
//
// Behaviour
// - Upper mask bits 30..0 enable physical handling for nodes 62..32.
// - Lower mask bit n enables physical handling for local node n, 0..31.
// - Local physical packets pass the async filter check, then the node mask check.
// - Clear mask bit for the source sends the request to async_request_rx_context.
// - Lower mask: write set address sets, clear address clears, both read mask.
// - Lower mask reads all zeros after reset.
// - Upper bound register reads zero and ignores writes.
// - Upper mask top bit accepts all remote-bus requests; survives bus reset.
// - Upper mask has its own set/clear addresses and resets to zero.
// - Node mask check applies to local sources only; remote uses top bit.
`timescale 1ns/1ps
`include "phys_filter_defs.vh"

module physical_request_node_filter #(
  parameter ADDR_W = 12,
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  input wire bus_reset_in,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Received packet from link core
  input wire pkt_valid_in,
  input wire [`NODE_NUM_W-1:0] pkt_src_node_in,
  input wire pkt_src_local_in,
  input wire pkt_phys_in,
  input wire async_filter_pass_in,
  // Routing decision
  output wire route_valid_out,
  output wire route_phys_out,
  output wire route_async_out,
  output wire route_reject_out,
  output wire [`NODE_NUM_W-1:0] route_node_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [`MASK_W-1:0] node_mask_r;
  reg [`MASK_W-1:0] node_mask_nxt;
  reg [ADDR_W-1:0] wr_addr_r;
  reg [31:0] wr_data_r;
  reg [3:0] wr_strb_r;
  reg aw_held_r;
  reg w_held_r;
  reg aw_held_nxt;
  reg w_held_nxt;
  reg bvalid_nxt;
  reg rvalid_nxt;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;
  reg [1:0] last_route_r;
  reg [`NODE_NUM_W-1:0] last_node_r;
  reg [CNT_W-1:0] cnt_phys_r;
  reg [CNT_W-1:0] cnt_async_r;
  reg [CNT_W-1:0] cnt_reject_r;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire wr_fire;
  wire [31:0] wr_lanes;
  wire [31:0] wr_ones;
  wire [ADDR_W-1:0] wr_word_addr;
  wire [ADDR_W-1:0] rd_word_addr;
  wire set_low;
  wire clr_low;
  wire set_high;
  wire clr_high;
  wire [`MASK_W-1:0] set_vec;
  wire [`MASK_W-1:0] clr_vec;
  wire [31:0] status_word;

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------
  assign aw_take = s_axi_awvalid_in & s_axi_awready_out;
  assign w_take = s_axi_wvalid_in & s_axi_wready_out;
  // Address and data may land in either order; act once both are held
  assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid_out;
  assign wr_word_addr = {wr_addr_r[ADDR_W-1:2], 2'b00};

  always @*
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    bvalid_nxt = s_axi_bvalid_out;
    if (aw_take)
      aw_held_nxt = 1'b1;
    if (w_take)
      w_held_nxt = 1'b1;
    if (wr_fire)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
    end
    else if (s_axi_bvalid_out && s_axi_bready_in)
      bvalid_nxt = 1'b0;
  end

  always @*
  begin
    case (wr_word_addr)
      `OFF_HIGH_SET, `OFF_HIGH_CLR, `OFF_LOW_SET, `OFF_LOW_CLR:
        wr_hit = 1'b1;
      `OFF_UPPER_BOUND, `OFF_STATUS, `OFF_CNT_ROUTE, `OFF_CNT_REJECT:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_addr_r <= {ADDR_W{1'b0}};
      wr_data_r <= 32'h0000_0000;
      wr_strb_r <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      if (aw_take)
        wr_addr_r <= s_axi_awaddr_in;
      if (w_take)
      begin
        wr_data_r <= s_axi_wdata_in;
        wr_strb_r <= s_axi_wstrb_in;
      end
      // Ready drops while a half or a response is pending
      s_axi_awready_out <= ~aw_held_nxt & ~bvalid_nxt;
      s_axi_wready_out <= ~w_held_nxt & ~bvalid_nxt;
      s_axi_bvalid_out <= bvalid_nxt;
      if (wr_fire)
        s_axi_bresp_out <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Node mask, set/clear per bit
  // ----------------------------------------------------------------
  assign wr_lanes = {{8{wr_strb_r[3]}}, {8{wr_strb_r[2]}}, {8{wr_strb_r[1]}}, {8{wr_strb_r[0]}}};
  assign wr_ones = wr_data_r & wr_lanes;
  assign set_low = wr_fire & (wr_word_addr == `OFF_LOW_SET);
  assign clr_low = wr_fire & (wr_word_addr == `OFF_LOW_CLR);
  assign set_high = wr_fire & (wr_word_addr == `OFF_HIGH_SET);
  assign clr_high = wr_fire & (wr_word_addr == `OFF_HIGH_CLR);
  assign set_vec = {wr_ones & {32{set_high}}, wr_ones & {32{set_low}}};
  assign clr_vec = {wr_ones & {32{clr_high}}, wr_ones & {32{clr_low}}};

  genvar gi;
  generate
    for (gi = 0; gi < `MASK_W; gi = gi + 1)
    begin : g_mask_bit
      always @*
      begin
        if (set_vec[gi])
          node_mask_nxt[gi] = 1'b1;
        else if (clr_vec[gi])
          node_mask_nxt[gi] = 1'b0;
        else if (bus_reset_in && (gi != `ALL_BUS_BIT))
          node_mask_nxt[gi] = 1'b0;
        else
          node_mask_nxt[gi] = node_mask_r[gi];
      end
    end
  endgenerate

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      node_mask_r <= {`MASK_HIGH_RST, `MASK_LOW_RST};
    else
      node_mask_r <= node_mask_nxt;
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_take = s_axi_arvalid_in & s_axi_arready_out;
  assign rd_word_addr = {s_axi_araddr_in[ADDR_W-1:2], 2'b00};
  assign status_word = {22'h00_0000, last_route_r, 2'h0, last_node_r};

  always @*
  begin
    rd_hit = 1'b1;
    case (rd_word_addr)
      `OFF_HIGH_SET, `OFF_HIGH_CLR:
        rd_word = node_mask_r[63:32];
      `OFF_LOW_SET, `OFF_LOW_CLR:
        rd_word = node_mask_r[31:0];
      `OFF_UPPER_BOUND:
        rd_word = `UPPER_BOUND_VAL;
      `OFF_STATUS:
        rd_word = status_word;
      `OFF_CNT_ROUTE:
        rd_word = {cnt_async_r, cnt_phys_r};
      `OFF_CNT_REJECT:
        rd_word = {{(32-CNT_W){1'b0}}, cnt_reject_r};
      default:
      begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @*
  begin
    rvalid_nxt = s_axi_rvalid_out;
    if (ar_take)
      rvalid_nxt = 1'b1;
    else if (s_axi_rvalid_out && s_axi_rready_in)
      rvalid_nxt = 1'b0;
  end

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid_out <= rvalid_nxt;
      s_axi_arready_out <= ~rvalid_nxt;
      if (ar_take)
      begin
        s_axi_rdata_out <= rd_word;
        s_axi_rresp_out <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Routing decision
  // ----------------------------------------------------------------
  phys_route_decide #(
    .NODE_W(`NODE_NUM_W),
    .MASK_W(`MASK_W)
  ) u_decide (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .node_mask_in(node_mask_r),
    .pkt_valid_in(pkt_valid_in),
    .pkt_src_node_in(pkt_src_node_in),
    .pkt_src_local_in(pkt_src_local_in),
    .pkt_phys_in(pkt_phys_in),
    .async_filter_pass_in(async_filter_pass_in),
    .route_valid_out(route_valid_out),
    .route_phys_out(route_phys_out),
    .route_async_out(route_async_out),
    .route_reject_out(route_reject_out),
    .route_node_out(route_node_out)
  );

  // ----------------------------------------------------------------
  // Status and counters
  // ----------------------------------------------------------------
  // Counters saturate so a long run never wraps to a small value
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      last_route_r <= `ROUTE_NONE;
      last_node_r <= {`NODE_NUM_W{1'b0}};
      cnt_phys_r <= {CNT_W{1'b0}};
      cnt_async_r <= {CNT_W{1'b0}};
      cnt_reject_r <= {CNT_W{1'b0}};
    end
    else if (route_valid_out)
    begin
      last_node_r <= route_node_out;
      if (route_phys_out)
      begin
        last_route_r <= `ROUTE_PHYS;
        if (~&cnt_phys_r)
          cnt_phys_r <= cnt_phys_r + 1'b1;
      end
      else if (route_async_out)
      begin
        last_route_r <= `ROUTE_ASYNC;
        if (~&cnt_async_r)
          cnt_async_r <= cnt_async_r + 1'b1;
      end
      else
      begin
        last_route_r <= `ROUTE_REJECT;
        if (~&cnt_reject_r)
          cnt_reject_r <= cnt_reject_r + 1'b1;
      end
    end
  end

endmodule

// file: phys_filter_props.sv
// Purpose: Port assertions for the physical request node filter
// Assumes: ADDR_W of 12, node numbers 6 bits wide
// Notes: Mask state is not modelled here; the bench checks routing by mask
`timescale 1ns/1ps
module phys_filter_props #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  // Register bus
  input wire [ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0] s_axi_rresp_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  // Packet and decision
  input wire pkt_valid_in,
  input wire [5:0] pkt_src_node_in,
  input wire pkt_src_local_in,
  input wire pkt_phys_in,
  input wire async_filter_pass_in,
  input wire route_valid_out,
  input wire route_phys_out,
  input wire route_async_out,
  input wire route_reject_out,
  input wire [5:0] route_node_out
);
  // ------
  // Assertions
  // ------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire aw_w_now = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  chk_route_follows: assert property (pkt_valid_in |=> route_valid_out)
    else $error("route result missing");
  chk_route_quiet: assert property (!pkt_valid_in |=> !(route_phys_out || route_async_out || route_reject_out))
    else $error("route bit without packet");
  chk_route_onehot: assert property (route_valid_out |-> $onehot({route_phys_out, route_async_out, route_reject_out}))
    else $error("route bits not one-hot");
  chk_route_node: assert property (pkt_valid_in |=> route_node_out == $past(pkt_src_node_in))
    else $error("route node wrong");
  chk_filter_reject: assert property (pkt_valid_in && pkt_phys_in && pkt_src_local_in && !async_filter_pass_in |=> route_reject_out)
    else $error("filtered source not rejected");
  chk_remote_no_async: assert property (pkt_valid_in && pkt_phys_in && !pkt_src_local_in |=> !route_async_out)
    else $error("remote request sent to async context");
  chk_bound_zero: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[11:2] == 10'h048
    |=> s_axi_rdata_out == 32'h0 && s_axi_rresp_out == 2'h0)
    else $error("upper bound read not zero");
  chk_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  chk_write_answer: assert property (aw_w_now |=> ##1 s_axi_bvalid_out)
    else $error("write response late");
  cov_phys: cover property (pkt_valid_in ##1 route_phys_out);
  cov_async: cover property (pkt_valid_in ##1 route_async_out);
  cov_reject: cover property (pkt_valid_in ##1 route_reject_out);
endmodule
bind physical_request_node_filter phys_filter_props #(.ADDR_W(ADDR_W)) u_props (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .pkt_valid_in(pkt_valid_in), .pkt_src_node_in(pkt_src_node_in),
  .pkt_src_local_in(pkt_src_local_in), .pkt_phys_in(pkt_phys_in), .async_filter_pass_in(async_filter_pass_in),
  .route_valid_out(route_valid_out), .route_phys_out(route_phys_out), .route_async_out(route_async_out),
  .route_reject_out(route_reject_out), .route_node_out(route_node_out));

// file: link_core_model.sv
// Purpose: Link core stand-in delivering received request packets
// Assumes: Caller sends, then idles, on consecutive edges
// Notes: Idle fields are inverted so stale values never pass for fresh ones
`timescale 1ns/1ps
module link_core_model (
  // Clock
  input wire logic mclk_in,
  // Packet to filter
  output logic pkt_valid_out,
  output logic [5:0] pkt_src_node_out,
  output logic pkt_src_local_out,
  output logic pkt_phys_out,
  output logic async_filter_pass_out
);
  // ------
  // Packet driver
  // ------
  initial
  begin
    pkt_valid_out = 1'h0;
    {pkt_src_node_out, pkt_src_local_out, pkt_phys_out, async_filter_pass_out} = 9'h0;
  end
  task send(input logic [5:0] n, input logic l, p, f);
    @(posedge mclk_in);
    pkt_valid_out <= 1'h1;
    {pkt_src_node_out, pkt_src_local_out, pkt_phys_out, async_filter_pass_out} <= {n, l, p, f};
  endtask
  task idle;
    @(posedge mclk_in);
    pkt_valid_out <= 1'h0;
    {pkt_src_node_out, pkt_src_local_out, pkt_phys_out, async_filter_pass_out} <=
      ~{pkt_src_node_out, pkt_src_local_out, pkt_phys_out, async_filter_pass_out};
  endtask
endmodule

// file: tb.sv
// Purpose: Register and routing tests of the node filter
// Assumes: Full byte strobes on every write
// Notes: Bus waits have no own limit; the watchdog cuts hangs
`timescale 1ns/1ps
module tb;
  localparam [2:0] PH = 3'h4, AS = 3'h2, RJ = 3'h1;
  localparam [1:0] OK = 2'h0, SE = 2'h2;
  logic mclk_in, rst_n_in, bus_reset_in, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  wire awready, wready, bvalid, arready, rvalid, rv, rp, ra, rj, pv, pl, pp, pf;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] rnode, pn;
  int mismatches, n_compared, rlag;
  physical_request_node_filter u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_reset_in(bus_reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .pkt_valid_in(pv), .pkt_src_node_in(pn), .pkt_src_local_in(pl), .pkt_phys_in(pp),
    .async_filter_pass_in(pf), .route_valid_out(rv), .route_phys_out(rp), .route_async_out(ra),
    .route_reject_out(rj), .route_node_out(rnode));
  link_core_model lc (.mclk_in(mclk_in), .pkt_valid_out(pv), .pkt_src_node_out(pn), .pkt_src_local_out(pl),
    .pkt_phys_out(pp), .async_filter_pass_out(pf));
  // ------
  // Shared tasks
  // ------
  task check(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk_in);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge mclk_in);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
    check(bresp, er);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk_in);
    araddr <= a;
    {arvalid, rready} <= {1'h1, rlag == 0};
    do
    begin
      @(posedge mclk_in);
      if (arready) arvalid <= 1'h0;
    end
    while (!rvalid);
    // Late rready keeps the answer waiting, so its hold is exercised
    if (rlag > 0)
    begin
      repeat (rlag) @(posedge mclk_in);
      rready <= 1'h1;
      @(posedge mclk_in);
    end
    rready <= 1'h0;
    check({rresp, rdata[29:0]}, {er, ed[29:0]});
    check(rdata, ed);
  endtask
  // Result is registered on the idle edge, one edge after the send launch
  task pkt(input logic [5:0] n, input logic l, p, f, input logic [2:0] e);
    lc.send(n, l, p, f);
    lc.idle;
    #1;
    check({rv, rp, ra, rj, rnode}, {1'h1, e, n});
  endtask
  task results;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------
  // Clock, watchdog, tests
  // ------
  initial
  begin
    mclk_in = 1'h0;
    forever #5 mclk_in = ~mclk_in;
  end
  initial
  begin
    #100000;
    mismatches++;
    results;
  end
  initial
  begin
    {mismatches, n_compared} = 0;
    {rst_n_in, bus_reset_in, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata} = 56'h0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    rd(12'h118, 32'h0, OK);
    rd(12'h11C, 32'h0, OK);
    rd(12'h110, 32'h0, OK);
    rd(12'h114, 32'h0, OK);
    wr(12'h118, 32'h80000001, OK);
    rd(12'h11C, 32'h80000001, OK);
    wr(12'h118, 32'h00000010, OK);
    rd(12'h118, 32'h80000011, OK);
    wr(12'h11C, 32'h80000000, OK);
    rd(12'h118, 32'h00000011, OK);
    wr(12'h120, 32'hFFFFFFFF, OK);
    rd(12'h120, 32'h0, OK);
    wr(12'h200, 32'hFFFFFFFF, SE);
    rd(12'h200, 32'h0, SE);
    wr(12'h110, 32'h00040001, OK);
    pkt(6'h32, 1'h1, 1'h1, 1'h1, PH);
    pkt(6'h31, 1'h1, 1'h1, 1'h1, AS);
    pkt(6'h20, 1'h1, 1'h1, 1'h1, PH);
    pkt(6'h04, 1'h1, 1'h1, 1'h1, PH);
    pkt(6'h01, 1'h1, 1'h1, 1'h1, AS);
    pkt(6'h1F, 1'h1, 1'h1, 1'h1, AS);
    pkt(6'h04, 1'h1, 1'h1, 1'h0, RJ);
    pkt(6'h32, 1'h0, 1'h1, 1'h1, RJ);
    pkt(6'h04, 1'h1, 1'h0, 1'h1, AS);
    pkt(6'h04, 1'h1, 1'h0, 1'h0, RJ);
    wr(12'h110, 32'h80000000, OK);
    pkt(6'h07, 1'h0, 1'h1, 1'h1, PH);
    wr(12'h114, 32'h00000001, OK);
    pkt(6'h20, 1'h1, 1'h1, 1'h1, AS);
    rd(12'h114, 32'h80040000, OK);
    @(posedge mclk_in);
    bus_reset_in <= 1'h1;
    @(posedge mclk_in);
    bus_reset_in <= 1'h0;
    rd(12'h110, 32'h80000000, OK);
    rd(12'h118, 32'h0, OK);
    pkt(6'h07, 1'h0, 1'h1, 1'h1, PH);
    rd(12'h124, 32'h00000107, OK);
    rd(12'h128, 32'h00050005, OK);
    rlag = 2;
    rd(12'h12C, 32'h00000003, OK);
    rlag = 0;
    results;
  end
endmodule
